//--- src/cdr_pkg.sv
// Package: register map, field layout and types of the comparator control block
package cdr_pkg;

  // ==========================================================================
  // Register offsets on the special-function-register bus
  localparam logic [7:0] CMP_B_CTL_ADDR = 8'h9A;
  localparam logic [7:0] CMP_A_CTL_ADDR = 8'h9B;
  localparam logic [7:0] CMP_B_MODE_ADDR = 8'h9C;
  localparam logic [7:0] CMP_A_MODE_ADDR = 8'h9D;
  localparam logic [7:0] CMP_A_MUX_ADDR = 8'h9F;
  localparam logic [7:0] CMP_B_MUX_ADDR = 8'h9F;

  // ==========================================================================
  // Reset values
  localparam logic [7:0] CTL_RST = 8'h00;
  localparam logic [7:0] MODE_RST = 8'h02;
  localparam logic [7:0] MUX_RST = 8'h00;

  // ==========================================================================
  // Field positions
  localparam int ON_BIT = 7;
  localparam int RES_BIT = 6;
  localparam int RISE_BIT = 5;
  localparam int FALL_BIT = 4;
  localparam int PHYS_LSB = 2;
  localparam int NHYS_LSB = 0;
  localparam int NSEL_LSB = 4;
  localparam int PSEL_LSB = 0;
  localparam int RIE_BIT = 5;
  localparam int FIE_BIT = 4;
  localparam int SPD_LSB = 0;

  // ==========================================================================
  // Settings presented to one analog comparator
  typedef struct packed {
    logic on;
    logic [1:0] pos_hyst;
    logic [1:0] neg_hyst;
    logic [1:0] pos_sel;
    logic [1:0] neg_sel;
    logic [1:0] speed_mode;
  } cdr_ana_t;

  // Whole state of one comparator channel
  typedef struct packed {
    cdr_ana_t ana;
    logic rise_flag;
    logic fall_flag;
    logic rise_irq_en;
    logic fall_irq_en;
    logic sync1;
    logic sync2;
    logic prev;
  } cdr_cmp_t;

  // Whole state of the block
  typedef struct packed {
    cdr_cmp_t a;
    cdr_cmp_t b;
    logic [7:0] rdata;
    logic irq_a;
    logic irq_b;
  } cdr_state_t;

  localparam cdr_cmp_t CMP_RST = '{
    ana: '{on: CTL_RST[ON_BIT],
           pos_hyst: CTL_RST[PHYS_LSB+:2],
           neg_hyst: CTL_RST[NHYS_LSB+:2],
           pos_sel: MUX_RST[PSEL_LSB+:2],
           neg_sel: MUX_RST[NSEL_LSB+:2],
           speed_mode: MODE_RST[SPD_LSB+:2]},
    rise_flag: CTL_RST[RISE_BIT],
    fall_flag: CTL_RST[FALL_BIT],
    rise_irq_en: MODE_RST[RIE_BIT],
    fall_irq_en: MODE_RST[FIE_BIT],
    default: 1'b0};

  localparam cdr_state_t STATE_RST = '{
    a: CMP_RST, b: CMP_RST, rdata: 8'h00, irq_a: 1'b0, irq_b: 1'b0};

endpackage

//--- src/cdr_regs.sv
// Control and status registers for two analog comparators
`timescale 1ns/1ps
`default_nettype none

module cdr_regs #(
  parameter logic [7:0] CMP_B_MUX_OFS = cdr_pkg::CMP_B_MUX_ADDR
) (
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic [7:0] SFR_ADDR,
  input wire logic SFR_WR,
  input wire logic SFR_RD,
  input wire logic [7:0] SFR_WDATA,
  output logic [7:0] SFR_RDATA,
  input wire logic CMP_A_RAW,
  input wire logic CMP_B_RAW,
  output cdr_pkg::cdr_ana_t CMP_A_ANA,
  output cdr_pkg::cdr_ana_t CMP_B_ANA,
  output logic CMP_A_IRQ,
  output logic CMP_B_IRQ
);

  // ==========================================================================
  // Channel helpers

  // Next state of one channel from its current state, pin and bus writes
  function automatic cdr_pkg::cdr_cmp_t cmp_next(
    input cdr_pkg::cdr_cmp_t c,
    input logic raw,
    input logic wr_ctl,
    input logic wr_mux,
    input logic wr_mode,
    input logic [7:0] d
  );
    cdr_pkg::cdr_cmp_t n;
    logic res;
    logic rise;
    logic fall;
    n = c;
    // two flops before any logic sees the pin
    n.sync1 = raw;
    n.sync2 = c.sync1;
    // output reads low while the comparator is off
    res = c.ana.on & c.sync2;
    n.prev = res;
    // rising edge seen only while enabled
    rise = res & ~c.prev;
    // falling edge also gated by the enable
    fall = c.ana.on & ~c.sync2 & c.prev;
    if (wr_ctl) begin
      n.ana.on = d[cdr_pkg::ON_BIT];
      n.rise_flag = d[cdr_pkg::RISE_BIT];
      n.fall_flag = d[cdr_pkg::FALL_BIT];
      n.ana.pos_hyst = d[cdr_pkg::PHYS_LSB+:2];
      n.ana.neg_hyst = d[cdr_pkg::NHYS_LSB+:2];
    end
    if (wr_mux) begin
      n.ana.neg_sel = d[cdr_pkg::NSEL_LSB+:2];
      n.ana.pos_sel = d[cdr_pkg::PSEL_LSB+:2];
    end
    if (wr_mode) begin
      n.rise_irq_en = d[cdr_pkg::RIE_BIT];
      n.fall_irq_en = d[cdr_pkg::FIE_BIT];
      n.ana.speed_mode = d[cdr_pkg::SPD_LSB+:2];
    end
    // set wins over a software clear in the same cycle
    n.rise_flag = n.rise_flag | rise;
    n.fall_flag = n.fall_flag | fall;
    return n;
  endfunction

  // Control register image; bit 6 is the live synchronised result
  function automatic logic [7:0] ctl_byte(input cdr_pkg::cdr_cmp_t c);
    // result bit reflects the synchronised output
    return {c.ana.on, c.ana.on & c.sync2, c.rise_flag, c.fall_flag,
            c.ana.pos_hyst, c.ana.neg_hyst};
  endfunction

  // Mux register image; unused bits fixed at zero
  function automatic logic [7:0] mux_byte(input cdr_pkg::cdr_cmp_t c);
    return {2'h0, c.ana.neg_sel, 2'h0, c.ana.pos_sel};
  endfunction

  // Mode register image; unused bits fixed at zero
  function automatic logic [7:0] mode_byte(input cdr_pkg::cdr_cmp_t c);
    return {2'h0, c.rise_irq_en, c.fall_irq_en, 2'h0, c.ana.speed_mode};
  endfunction

  // Interrupt request of one channel
  function automatic logic irq_of(input cdr_pkg::cdr_cmp_t c);
    return (c.rise_flag & c.rise_irq_en) | (c.fall_flag & c.fall_irq_en);
  endfunction

  // ==========================================================================
  // State

  cdr_pkg::cdr_state_t state_r;
  cdr_pkg::cdr_state_t state_nxt;

  logic wr_a_ctl;
  logic wr_b_ctl;
  logic wr_a_mux;
  logic wr_b_mux;
  logic wr_a_mode;
  logic wr_b_mode;

  // Write decode; both mux offsets may coincide, then one write hits both
  assign wr_a_ctl = SFR_WR && (SFR_ADDR == cdr_pkg::CMP_A_CTL_ADDR);
  assign wr_b_ctl = SFR_WR && (SFR_ADDR == cdr_pkg::CMP_B_CTL_ADDR);
  assign wr_a_mux = SFR_WR && (SFR_ADDR == cdr_pkg::CMP_A_MUX_ADDR);
  assign wr_b_mux = SFR_WR && (SFR_ADDR == CMP_B_MUX_OFS);
  assign wr_a_mode = SFR_WR && (SFR_ADDR == cdr_pkg::CMP_A_MODE_ADDR);
  assign wr_b_mode = SFR_WR && (SFR_ADDR == cdr_pkg::CMP_B_MODE_ADDR);

  // Next-state logic for both channels, read data and interrupts
  always_comb begin
    state_nxt = state_r;
    state_nxt.a = cmp_next(state_r.a, CMP_A_RAW, wr_a_ctl, wr_a_mux,
                           wr_a_mode, SFR_WDATA);
    // second channel shares the mode layout
    // second channel shares the control layout
    // second negative select via the same helper
    // second positive select via the same helper
    state_nxt.b = cmp_next(state_r.b, CMP_B_RAW, wr_b_ctl, wr_b_mux,
                           wr_b_mode, SFR_WDATA);
    // Read data is captured on the strobe and held until the next read
    if (SFR_RD) begin
      if (SFR_ADDR == cdr_pkg::CMP_A_CTL_ADDR) begin
        state_nxt.rdata = ctl_byte(state_r.a);
      end else if (SFR_ADDR == cdr_pkg::CMP_B_CTL_ADDR) begin
        state_nxt.rdata = ctl_byte(state_r.b);
      end else if (SFR_ADDR == cdr_pkg::CMP_A_MODE_ADDR) begin
        state_nxt.rdata = mode_byte(state_r.a);
      end else if (SFR_ADDR == cdr_pkg::CMP_B_MODE_ADDR) begin
        state_nxt.rdata = mode_byte(state_r.b);
      end else if (SFR_ADDR == cdr_pkg::CMP_A_MUX_ADDR) begin
        state_nxt.rdata = mux_byte(state_r.a);
      end else if (SFR_ADDR == CMP_B_MUX_OFS) begin
        state_nxt.rdata = mux_byte(state_r.b);
      end else begin
        state_nxt.rdata = 8'h00;
      end
    end
    // request from the flags being written this cycle
    state_nxt.irq_a = irq_of(state_nxt.a);
    state_nxt.irq_b = irq_of(state_nxt.b);
  end

  // State register
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      state_r <= cdr_pkg::STATE_RST;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Outputs all straight from flops
  assign SFR_RDATA = state_r.rdata;
  assign CMP_A_ANA = state_r.a.ana;
  assign CMP_B_ANA = state_r.b.ana;
  assign CMP_A_IRQ = state_r.irq_a;
  assign CMP_B_IRQ = state_r.irq_b;

  // ==========================================================================
  // Checks

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_N);

  enable_write_a: assert property (
    wr_a_ctl |=> CMP_A_ANA.on == $past(SFR_WDATA[7]))
    else $error("enable bit did not follow write");

  result_off_a: assert property (
    (SFR_RD && SFR_ADDR == cdr_pkg::CMP_A_CTL_ADDR && !state_r.a.ana.on)
    |=> !SFR_RDATA[6])
    else $error("result read high while comparator off");

  result_read_a: assert property (
    (SFR_RD && SFR_ADDR == cdr_pkg::CMP_B_CTL_ADDR)
    |=> SFR_RDATA[6] == $past(state_r.b.ana.on && state_r.b.sync2))
    else $error("result bit does not match synchronised output");

  rise_set_a: assert property (
    (state_r.a.ana.on && state_r.a.sync2 && !state_r.a.prev)
    |=> state_r.a.rise_flag)
    else $error("rising edge did not set flag");

  fall_set_a: assert property (
    (state_r.b.ana.on && !state_r.b.sync2 && state_r.b.prev)
    |=> state_r.b.fall_flag)
    else $error("falling edge did not set flag");

  flag_sticky_a: assert property (
    (state_r.a.rise_flag && !wr_a_ctl) |=> state_r.a.rise_flag)
    else $error("rise flag cleared without a write");

  hyst_write_a: assert property (
    wr_b_ctl |=> CMP_B_ANA.pos_hyst == $past(SFR_WDATA[3:2])
                 && CMP_B_ANA.neg_hyst == $past(SFR_WDATA[1:0]))
    else $error("hysteresis codes did not follow write");

  mux_unused_a: assert property (
    (SFR_RD && SFR_ADDR == cdr_pkg::CMP_A_MUX_ADDR)
    |=> SFR_RDATA[7:6] == 2'h0 && SFR_RDATA[3:2] == 2'h0)
    else $error("unused mux bits read nonzero");

  speed_write_a: assert property (
    wr_a_mode |=> CMP_A_ANA.speed_mode == $past(SFR_WDATA[1:0])
                  ##1 CMP_A_ANA.speed_mode == $past(SFR_WDATA[1:0], 2)
                      || $past(wr_a_mode))
    else $error("speed mode did not follow write");

  irq_tie_a: assert property (
    CMP_A_IRQ == ((state_r.a.rise_flag && state_r.a.rise_irq_en)
                  || (state_r.a.fall_flag && state_r.a.fall_irq_en)))
    else $error("interrupt does not match flags and enables");

  enable_write_b_a: assert property (
    wr_b_ctl |=> CMP_B_ANA.on == $past(SFR_WDATA[7]))
    else $error("second enable bit did not follow write");

  first_neg_sel_a: assert property (
    wr_a_mux |=> CMP_A_ANA.neg_sel == $past(SFR_WDATA[5:4]))
    else $error("first negative select did not follow write");

  first_pos_sel_a: assert property (
    wr_a_mux |=> CMP_A_ANA.pos_sel == $past(SFR_WDATA[1:0]))
    else $error("first positive select did not follow write");

  second_neg_sel_a: assert property (
    wr_b_mux |=> CMP_B_ANA.neg_sel == $past(SFR_WDATA[5:4]))
    else $error("second negative select did not follow write");

  second_pos_sel_a: assert property (
    wr_b_mux |=> CMP_B_ANA.pos_sel == $past(SFR_WDATA[1:0]))
    else $error("second positive select did not follow write");

  rise_enable_a: assert property (
    wr_a_mode |=> state_r.a.rise_irq_en == $past(SFR_WDATA[5]))
    else $error("rising interrupt enable did not follow write");

  fall_enable_a: assert property (
    wr_a_mode |=> state_r.a.fall_irq_en == $past(SFR_WDATA[4]))
    else $error("falling interrupt enable did not follow write");

  mode_write_b_a: assert property (
    wr_b_mode |=> CMP_B_ANA.speed_mode == $past(SFR_WDATA[1:0])
                  && state_r.b.rise_irq_en == $past(SFR_WDATA[5])
                  && state_r.b.fall_irq_en == $past(SFR_WDATA[4]))
    else $error("second mode register did not follow write");

  off_no_flag_a: assert property (
    (!state_r.a.ana.on && !state_r.a.rise_flag && !wr_a_ctl)
    |=> !state_r.a.rise_flag)
    else $error("rise flag set while comparator off");

  fall_sticky_b_a: assert property (
    (state_r.b.fall_flag && !wr_b_ctl) |=> state_r.b.fall_flag)
    else $error("second fall flag cleared without a write");

  rise_set_b_a: assert property (
    (state_r.b.ana.on && state_r.b.sync2 && !state_r.b.prev)
    |=> state_r.b.rise_flag)
    else $error("second rising edge did not set flag");

  hyst_read_a: assert property (
    (SFR_RD && SFR_ADDR == cdr_pkg::CMP_A_CTL_ADDR)
    |=> SFR_RDATA[3:0] == $past({state_r.a.ana.pos_hyst,
                                 state_r.a.ana.neg_hyst}))
    else $error("hysteresis codes read back wrong");

  mode_unused_a: assert property (
    (SFR_RD && SFR_ADDR == cdr_pkg::CMP_B_MODE_ADDR)
    |=> SFR_RDATA[7:6] == 2'h0 && SFR_RDATA[3:2] == 2'h0)
    else $error("unused mode bits read nonzero");

  irq_tie_b_a: assert property (
    CMP_B_IRQ == ((state_r.b.rise_flag && state_r.b.rise_irq_en)
                  || (state_r.b.fall_flag && state_r.b.fall_irq_en)))
    else $error("second interrupt does not match flags and enables");

endmodule

`default_nettype wire

//--- tb/cdr_cmp_model.sv
// Behavioural analog comparator standing behind one register channel
`timescale 1ns/1ps
`default_nettype none

module cdr_cmp_model (
  input wire cdr_pkg::cdr_ana_t ana,
  input wire logic level,
  output logic raw
);
  // ====================
  // Output stage
  // Powered down it drives low; the delay keeps edges off the clock edge
  assign #3 raw = ana.on & level;
endmodule

`default_nettype wire

//--- tb/dual_comparator_control_regs_tb.sv
// Self-checking testbench for the comparator control registers
`timescale 1ns/1ps
`default_nettype none

module dual_comparator_control_regs_tb;
  logic CLOCK = 1'b0;
  logic RST_N = 1'b0;
  logic [7:0] SFR_ADDR = 8'h00;
  logic SFR_WR = 1'b0;
  logic SFR_RD = 1'b0;
  logic [7:0] SFR_WDATA = 8'h00;
  wire logic [7:0] SFR_RDATA;
  wire logic CMP_A_RAW, CMP_B_RAW, CMP_A_IRQ, CMP_B_IRQ;
  wire cdr_pkg::cdr_ana_t CMP_A_ANA, CMP_B_ANA;
  logic [1:0] lvl = 2'b00;
  logic [7:0] m [256];
  logic [7:0] ctl_a [2] = '{8'h9B, 8'h9A};
  logic [7:0] mode_a [2] = '{8'h9D, 8'h9C};
  logic [7:0] mux_a [2] = '{8'h9F, 8'h9E};
  int fail_count = 0;
  int total_checks = 0;
  int seed = 5;
  logic [7:0] d;
  logic [3:0] xs;
  logic [15:0] sh;
  wire cdr_pkg::cdr_ana_t sh_a_ana, sh_b_ana;

  // ====================
  // Clock, design and comparator models
  always #20 CLOCK = ~CLOCK;
  // Separate mux offset for B so both mux registers can be seen
  cdr_regs #(.CMP_B_MUX_OFS(8'h9E)) uut (.CLOCK(CLOCK), .RST_N(RST_N),
    .SFR_ADDR(SFR_ADDR), .SFR_WR(SFR_WR), .SFR_RD(SFR_RD),
    .SFR_WDATA(SFR_WDATA), .SFR_RDATA(SFR_RDATA),
    .CMP_A_RAW(CMP_A_RAW), .CMP_B_RAW(CMP_B_RAW),
    .CMP_A_ANA(CMP_A_ANA), .CMP_B_ANA(CMP_B_ANA),
    .CMP_A_IRQ(CMP_A_IRQ), .CMP_B_IRQ(CMP_B_IRQ));
  cdr_cmp_model cmp_a (.ana(CMP_A_ANA), .level(lvl[0]), .raw(CMP_A_RAW));
  cdr_cmp_model cmp_b (.ana(CMP_B_ANA), .level(lvl[1]), .raw(CMP_B_RAW));
  // Default layout: both mux registers share one offset, one write hits both
  cdr_regs uut_shared (.CLOCK(CLOCK), .RST_N(RST_N),
    .SFR_ADDR(SFR_ADDR), .SFR_WR(SFR_WR), .SFR_RD(SFR_RD),
    .SFR_WDATA(SFR_WDATA), .SFR_RDATA(),
    .CMP_A_RAW(1'b0), .CMP_B_RAW(1'b0),
    .CMP_A_ANA(sh_a_ana), .CMP_B_ANA(sh_b_ana),
    .CMP_A_IRQ(), .CMP_B_IRQ());

  // ====================
  // Bus tasks and comparisons
  task automatic chk(input string what, input logic [15:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Model keeps only the writable bits; flags follow software writes
  task automatic wr(input logic [7:0] a, dat);
    @(posedge CLOCK);
    #1;
    SFR_ADDR = a;
    SFR_WDATA = dat;
    SFR_WR = 1'b1;
    @(posedge CLOCK);
    #1;
    SFR_WR = 1'b0;
    if (a inside {8'h9C, 8'h9D, 8'h9E, 8'h9F}) m[a] = dat & 8'h33;
    else if (a inside {8'h9A, 8'h9B}) m[a] = dat & 8'hBF;
  endtask

  // Result bit is live: on and the comparator level together
  task automatic rchk(input logic [7:0] a);
    logic [7:0] e;
    e = m[a];
    for (int i = 0; i < 2; i++)
      if (a == ctl_a[i] && e[7] && lvl[i]) e[6] = 1'b1;
    @(posedge CLOCK);
    #1;
    SFR_ADDR = a;
    SFR_RD = 1'b1;
    @(posedge CLOCK);
    #1;
    SFR_RD = 1'b0;
    chk("rdata", {8'h00, SFR_RDATA}, {8'h00, e});
  endtask

  task automatic achk(input int i);
    logic [7:0] c, x, o;
    c = m[ctl_a[i]];
    x = m[mux_a[i]];
    o = m[mode_a[i]];
    chk("ana", {5'h00, i ? CMP_B_ANA : CMP_A_ANA},
        {5'h00, c[7], c[3:2], c[1:0], x[1:0], x[5:4], o[1:0]});
  endtask

  task automatic ichk(input int i);
    logic [7:0] c, o;
    c = m[ctl_a[i]];
    o = m[mode_a[i]];
    chk("irq", {15'h0000, i ? CMP_B_IRQ : CMP_A_IRQ},
        {15'h0000, (c[5] & o[5]) | (c[4] & o[4])});
  endtask

  // Level change; flags only while on, checked after the sync delay
  task automatic drive(input int i, input logic v);
    @(posedge CLOCK);
    #1;
    if (m[ctl_a[i]][7] && v !== lvl[i]) m[ctl_a[i]][v ? 5 : 4] = 1'b1;
    lvl[i] = v;
    repeat (4) @(posedge CLOCK);
    #1;
    ichk(i);
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ====================
  // Watchdog, far above the few hundred cycles the tests need
  initial begin
    #400000;
    fail_count++;
    end_sim();
  end

  // ====================
  // Main sequence
  initial begin
    for (int k = 0; k < 256; k++) m[k] = 8'h00;
    m[8'h9C] = 8'h02;
    m[8'h9D] = 8'h02;
    repeat (12) @(posedge CLOCK);
    #1;
    RST_N = 1'b1;
    for (int a = 8'h98; a < 8'hA2; a++) rchk(a[7:0]);
    achk(0);
    achk(1);
    $display("test reset values done");
    // Level held low so random enables latch no edges
    for (int n = 0; n < 6; n++) begin
      for (int i = 0; i < 2; i++) begin
        d = 8'($random(seed));
        wr(ctl_a[i], d & 8'h8F);
        d = 8'($random(seed));
        wr(mode_a[i], d);
        d = 8'($random(seed));
        wr(mux_a[i], d);
        achk(i);
        // Shared-offset copy follows only the writes to the common offset
        xs = {m[8'h9F][1:0], m[8'h9F][5:4]};
        sh = {8'h00, sh_a_ana[5:2], sh_b_ana[5:2]};
        chk("shared mux", sh, {8'h00, xs, xs});
        rchk(ctl_a[i]);
        rchk(mode_a[i]);
        rchk(mux_a[i]);
      end
    end
    $display("test random fields done");
    for (int i = 0; i < 2; i++) begin
      // enable with level low and flags written clear
      wr(ctl_a[i], 8'h80);
      wr(mode_a[i], 8'h20);
      drive(i, 1'b1);
      rchk(ctl_a[i]);
      drive(i, 1'b0);
      rchk(ctl_a[i]);
      wr(mode_a[i], 8'h10);
      drive(i, 1'b1);
      rchk(ctl_a[i]);
      wr(ctl_a[i], 8'h80);
      rchk(ctl_a[i]);
      ichk(i);
      wr(ctl_a[i], 8'h00);
      drive(i, 1'b0);
      drive(i, 1'b1);
      rchk(ctl_a[i]);
      achk(i);
    end
    $display("test edge flags done");
    end_sim();
  end
endmodule

`default_nettype wire
